// *** verilog/pcdaf_map.svh ***
// Register offsets, field positions and reset values of the port override block.
`ifndef PCDAF_MAP_SVH
`define PCDAF_MAP_SVH
`define PCDAF_OFF_PORTC  8'h00
`define PCDAF_OFF_DDRC   8'h04
`define PCDAF_OFF_PINC   8'h08
`define PCDAF_OFF_PORTD  8'h0c
`define PCDAF_OFF_DDRD   8'h10
`define PCDAF_OFF_PIND   8'h14
`define PCDAF_OFF_CTRL   8'h18
`define PCDAF_OFF_MASKC  8'h1c
`define PCDAF_OFF_MASKD  8'h20
`define PCDAF_OFF_ISTS   8'h24
`define PCDAF_OFF_IMASK  8'h28
`define PCDAF_CTRL_PUD   0
`define PCDAF_CTRL_PIN_CHANGE_GROUP1_EN 1
`define PCDAF_CTRL_PCIE2 2
`define PCDAF_RST_BYTE   8'h00
`define PCDAF_CMM_EXT    2'h3
`define PCDAF_T2M_SPI    4'h9
`define PCDAF_RESP_OK    2'h0
`define PCDAF_RESP_ERR   2'h2
`endif

// *** verilog/pcdaf_pkg.sv ***
// Types shared by the port C and port D alternate function override block.
package pcdaf_pkg;
    typedef struct packed {
        logic       clock_out_fuse;
        logic [1:0] clock_mode_bits;
        logic       clock_input_select;
        logic       clock_source_select;
    } pcdaf_clkcfg_t;
    typedef struct packed {
        logic [3:0] timer2_mode_field;
        logic       timer2_mod_out_1;
        logic       timer2_mod_out_2;
        logic       out_1_en;
        logic       out_2_en;
    } pcdaf_timer2_t;
    typedef struct packed {
        logic out;
        logic oe_n;
        logic pu;
    } pcdaf_pin_t;
    typedef struct packed {
        logic       awready;
        logic       wready;
        logic       bvalid;
        logic [1:0] bresp;
        logic       arready;
        logic       rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic       aw_have;
        logic [7:0] waddr;
        logic       w_have;
        logic [7:0] wdata;
        logic       wen;
        logic [2:0] portc;
        logic [2:0] ddrc;
        logic [7:0] portd;
        logic [7:0] ddrd;
        logic       global_pullup_disable;
        logic       pin_change_group1_en;
        logic       pcie2;
        logic [2:0] maskc;
        logic [7:0] maskd;
        logic [1:0] ists;
        logic [1:0] imask;
        logic       irq;
        logic [2:0] pinc;
        logic [7:0] pind;
        logic [2:0] pc_out;
        logic [2:0] pc_oe_n;
        logic [2:0] pc_pu;
        logic [7:0] pd_out;
        logic [7:0] pd_oe_n;
        logic [7:0] pd_pu;
        logic [2:0] pcint_c;
        logic [7:0] pcint_d;
        logic       ext_clock_in_0;
        logic       ext_clock_in_1;
        logic       serial_data_in_pin;
        logic       ext_irq_0;
        logic       ext_irq_1;
        logic       t3i;
        logic       timer2_capture_in;
    } pcdaf_state_t;
endpackage : pcdaf_pkg

// *** verilog/pcdaf_top.sv ***
// Port C and port D alternate function override logic with an AXI4-Lite register slave.
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pcdaf_map.svh"
// Overview of operation
// RULE1 - Clock fuse drives divided clock on C1.
// RULE2 - Clock output continues while reset asserted.
// RULE3 - Clock output: pull-up off, output, I/O clock.
// RULE4 - C0 becomes clock input 0, forced input.
// RULE5 - C0 data, direction, pin read zero.
// RULE6 - D4 becomes clock input 1, forced input.
// RULE7 - D4 data, direction, pin read zero.
// RULE8 - Port C pin-change sources, gated by mask.
// RULE9 - Timer2 SPI mode forces D7 input.
// RULE10 - Forced D7 pull-up follows data bit.
// RULE11 - D6 carries timer2 modulator output 2.
// RULE12 - D5 carries timer2 modulator output 1.
// RULE13 - Unused modulator pin stays plain I/O.
// RULE14 - D3 feeds external interrupt 1.
// RULE15 - D2 feeds external interrupt 0.
// RULE16 - D1 feeds external timer count clock.
// RULE17 - Port D pins feed pin-change sources 16..23.
// RULE18 - Global pull-up disable kills all pull-ups.
module pcdaf_top (
    input  wire logic                   CLOCK,
    input  wire logic                   RST_N,
    input  wire logic [7:0]             S_AXI_AWADDR,
    input  wire logic                   S_AXI_AWVALID,
    output logic                        S_AXI_AWREADY,
    input  wire logic [31:0]            S_AXI_WDATA,
    input  wire logic [3:0]             S_AXI_WSTRB,
    input  wire logic                   S_AXI_WVALID,
    output logic                        S_AXI_WREADY,
    output logic [1:0]                  S_AXI_BRESP,
    output logic                        S_AXI_BVALID,
    input  wire logic                   S_AXI_BREADY,
    input  wire logic [7:0]             S_AXI_ARADDR,
    input  wire logic                   S_AXI_ARVALID,
    output logic                        S_AXI_ARREADY,
    output logic [31:0]                 S_AXI_RDATA,
    output logic [1:0]                  S_AXI_RRESP,
    output logic                        S_AXI_RVALID,
    input  wire logic                   S_AXI_RREADY,
    input  wire pcdaf_pkg::pcdaf_clkcfg_t CFG,
    input  wire pcdaf_pkg::pcdaf_timer2_t T2,
    input  wire logic                   CLK_IO_DIV,
    input  wire logic [1:0]             EXT_IRQ_EN,
    input  wire logic [2:0]             PC_IN,
    input  wire logic [7:0]             PD_IN,
    output logic [2:0]                  PC_OUT,
    output logic [2:0]                  PC_OE_N,
    output logic [2:0]                  PC_PULLUP,
    output logic [7:0]                  PD_OUT,
    output logic [7:0]                  PD_OE_N,
    output logic [7:0]                  PD_PULLUP,
    output logic [2:0]                  PC_PCINT,
    output logic [7:0]                  PD_PCINT,
    output logic                        EXT_CLOCK_IN_0,
    output logic                        EXT_CLOCK_IN_1,
    output logic                        SERIAL_DATA_IN,
    output logic                        EXT_IRQ_0,
    output logic                        EXT_IRQ_1,
    output logic                        TIMER_EXT_COUNT_CLOCK,
    output logic                        TIMER2_CAPTURE_IN,
    output logic                        IRQ
);

    pcdaf_pkg::pcdaf_state_t s_reg;
    pcdaf_pkg::pcdaf_state_t s_next;
    pcdaf_pkg::pcdaf_pin_t   pin1_reg;
    pcdaf_pkg::pcdaf_pin_t   pin1_next;
    logic                    clkin0;
    logic                    clkin1;
    logic                    spi;
    logic [2:0]              pc_dir;
    logic [7:0]              pd_dir;
    logic [2:0]              pc_val;
    logic [7:0]              pd_val;
    logic [2:0]              pc_ien;
    logic [7:0]              pd_ien;
    logic [1:0]              ev;
    logic                    hit;
    logic [7:0]              rd;

    ////////////////////////////////////////////////////////////////////////
    // Pin override decode.

    assign clkin0 = (CFG.clock_mode_bits == `PCDAF_CMM_EXT) &&
                    !CFG.clock_input_select && CFG.clock_source_select; // RULE4
    assign clkin1 = (CFG.clock_mode_bits == `PCDAF_CMM_EXT) &&
                    CFG.clock_input_select && CFG.clock_source_select; // RULE6
    assign spi    = (T2.timer2_mode_field == `PCDAF_T2M_SPI); // RULE9
    assign pc_ien = s_reg.maskc & {3{s_reg.pin_change_group1_en}}; // RULE8
    assign pd_ien = s_reg.maskd & {8{s_reg.pcie2}}; // RULE17

    always_comb begin
        s_next = s_reg;
        pin1_next = '{out: 1'b0, oe_n: 1'b1, pu: 1'b0};
        pc_dir = s_reg.ddrc;
        pd_dir = s_reg.ddrd;
        pc_val = s_reg.portc;
        pd_val = s_reg.portd;
        hit    = 1'b1;
        rd     = `PCDAF_RST_BYTE;
        ev     = 2'h0;

        // Direction and value overrides; pull-up is data bit on an input pin unless pull-ups are globally disabled.
        pc_dir[0] = s_reg.ddrc[0] & ~clkin0; // RULE4
        pd_dir[4] = s_reg.ddrd[4] & ~clkin1; // RULE6
        pd_dir[7] = s_reg.ddrd[7] & ~spi; // RULE9
        if (T2.out_1_en) begin
            pd_val[5] = T2.timer2_mod_out_1; // RULE12
        end
        if (T2.out_2_en) begin
            pd_val[6] = T2.timer2_mod_out_2; // RULE11
        end
        s_next.pc_oe_n = ~pc_dir;
        s_next.pc_out  = pc_val;
        s_next.pc_pu   = s_reg.portc & ~pc_dir & {3{~s_reg.global_pullup_disable}}; // RULE18
        s_next.pd_oe_n = ~pd_dir; // RULE13
        s_next.pd_out  = pd_val; // RULE13
        s_next.pd_pu   = s_reg.portd & ~pd_dir & {8{~s_reg.global_pullup_disable}}; // RULE10
        if (CFG.clock_out_fuse) begin
            pin1_next = '{out: CLK_IO_DIV, oe_n: 1'b0, pu: 1'b0}; // RULE1 RULE3
        end else begin
            pin1_next = '{out: pc_val[1], oe_n: ~pc_dir[1], pu: s_next.pc_pu[1]};
        end

        // Alternate function inputs.
        s_next.pinc    = PC_IN;
        s_next.pind    = PD_IN;
        s_next.pcint_c = PC_IN & pc_ien; // RULE8
        s_next.pcint_d = PD_IN & pd_ien; // RULE17
        s_next.ext_clock_in_0   = PC_IN[0] & clkin0; // RULE4
        s_next.ext_clock_in_1   = PD_IN[4] & clkin1; // RULE6
        s_next.serial_data_in_pin    = PD_IN[7] & spi;
        s_next.ext_irq_1    = PD_IN[3] & (EXT_IRQ_EN[1] | pd_ien[3]); // RULE14
        s_next.ext_irq_0    = PD_IN[2] & (EXT_IRQ_EN[0] | pd_ien[2]); // RULE15
        s_next.t3i     = PD_IN[1]; // RULE16
        s_next.timer2_capture_in   = PD_IN[0];
        ev[0] = |((PC_IN ^ s_reg.pinc) & pc_ien);
        ev[1] = |((PD_IN ^ s_reg.pind) & pd_ien);

        // Write channel: address and data are taken in either order.
        if (S_AXI_AWVALID && s_reg.awready) begin
            s_next.aw_have = 1'b1;
            s_next.waddr   = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && s_reg.wready) begin
            s_next.w_have = 1'b1;
            s_next.wdata  = S_AXI_WDATA[7:0];
            s_next.wen    = S_AXI_WSTRB[0];
        end
        if (s_reg.bvalid && S_AXI_BREADY) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.aw_have && s_reg.w_have) begin
            s_next.aw_have = 1'b0;
            s_next.w_have  = 1'b0;
            s_next.bvalid  = 1'b1;
            case (s_reg.waddr)
                `PCDAF_OFF_PORTC: if (s_reg.wen) s_next.portc = s_reg.wdata[2:0];
                `PCDAF_OFF_DDRC:  if (s_reg.wen) s_next.ddrc  = s_reg.wdata[2:0];
                `PCDAF_OFF_PORTD: if (s_reg.wen) s_next.portd = s_reg.wdata;
                `PCDAF_OFF_DDRD:  if (s_reg.wen) s_next.ddrd  = s_reg.wdata;
                `PCDAF_OFF_MASKC: if (s_reg.wen) s_next.maskc = s_reg.wdata[2:0];
                `PCDAF_OFF_MASKD: if (s_reg.wen) s_next.maskd = s_reg.wdata;
                `PCDAF_OFF_IMASK: if (s_reg.wen) s_next.imask = s_reg.wdata[1:0];
                `PCDAF_OFF_PINC, `PCDAF_OFF_PIND: hit = 1'b1;
                `PCDAF_OFF_CTRL: begin
                    if (s_reg.wen) begin
                        s_next.global_pullup_disable   = s_reg.wdata[`PCDAF_CTRL_PUD];
                        s_next.pin_change_group1_en = s_reg.wdata[`PCDAF_CTRL_PIN_CHANGE_GROUP1_EN];
                        s_next.pcie2 = s_reg.wdata[`PCDAF_CTRL_PCIE2];
                    end
                end
                `PCDAF_OFF_ISTS: begin
                    if (s_reg.wen) begin
                        s_next.ists = s_reg.ists & ~s_reg.wdata[1:0];
                    end
                end
                default: hit = 1'b0;
            endcase
            s_next.bresp = hit ? `PCDAF_RESP_OK : `PCDAF_RESP_ERR;
        end
        // A change seen in the cycle of a clear still sets the flag.
        s_next.ists = s_next.ists | ev;
        s_next.irq  = |(s_next.ists & s_next.imask);

        // Read channel; a pin claimed as clock input reads as zero.
        case (S_AXI_ARADDR)
            `PCDAF_OFF_PORTC: rd = {5'h00, s_reg.portc & {2'h3, ~clkin0}}; // RULE5
            `PCDAF_OFF_DDRC:  rd = {5'h00, s_reg.ddrc & {2'h3, ~clkin0}}; // RULE5
            `PCDAF_OFF_PINC:  rd = {5'h00, s_reg.pinc & {2'h3, ~clkin0}}; // RULE5
            `PCDAF_OFF_PORTD: rd = s_reg.portd & ~{3'h0, clkin1, 4'h0}; // RULE7
            `PCDAF_OFF_DDRD:  rd = s_reg.ddrd & ~{3'h0, clkin1, 4'h0}; // RULE7
            `PCDAF_OFF_PIND:  rd = s_reg.pind & ~{3'h0, clkin1, 4'h0}; // RULE7
            `PCDAF_OFF_CTRL:  rd = {5'h00, s_reg.pcie2, s_reg.pin_change_group1_en, s_reg.global_pullup_disable};
            `PCDAF_OFF_MASKC: rd = {5'h00, s_reg.maskc};
            `PCDAF_OFF_MASKD: rd = s_reg.maskd;
            `PCDAF_OFF_ISTS:  rd = {6'h00, s_reg.ists};
            `PCDAF_OFF_IMASK: rd = {6'h00, s_reg.imask};
            default:          rd = `PCDAF_RST_BYTE;
        endcase
        if (s_reg.rvalid && S_AXI_RREADY) begin
            s_next.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rdata  = rd;
            s_next.rresp  = (S_AXI_ARADDR > `PCDAF_OFF_IMASK || S_AXI_ARADDR[1:0] != 2'h0)
                            ? `PCDAF_RESP_ERR : `PCDAF_RESP_OK;
        end
        s_next.awready = !s_next.aw_have && !s_next.bvalid;
        s_next.wready  = !s_next.w_have && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers.

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // The clock output pin has no reset so the clock keeps running in reset.
    always_ff @(posedge CLOCK) begin
        pin1_reg <= pin1_next; // RULE2
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign S_AXI_AWREADY         = s_reg.awready;
    assign S_AXI_WREADY          = s_reg.wready;
    assign S_AXI_BVALID          = s_reg.bvalid;
    assign S_AXI_BRESP           = s_reg.bresp;
    assign S_AXI_ARREADY         = s_reg.arready;
    assign S_AXI_RVALID          = s_reg.rvalid;
    assign S_AXI_RRESP           = s_reg.rresp;
    assign S_AXI_RDATA           = {24'h000000, s_reg.rdata};
    assign PC_OUT                = {s_reg.pc_out[2], pin1_reg.out, s_reg.pc_out[0]};
    assign PC_OE_N               = {s_reg.pc_oe_n[2], pin1_reg.oe_n, s_reg.pc_oe_n[0]};
    assign PC_PULLUP             = {s_reg.pc_pu[2], pin1_reg.pu, s_reg.pc_pu[0]};
    assign PD_OUT                = s_reg.pd_out;
    assign PD_OE_N               = s_reg.pd_oe_n;
    assign PD_PULLUP             = s_reg.pd_pu;
    assign PC_PCINT              = s_reg.pcint_c;
    assign PD_PCINT              = s_reg.pcint_d;
    assign EXT_CLOCK_IN_0        = s_reg.ext_clock_in_0;
    assign EXT_CLOCK_IN_1        = s_reg.ext_clock_in_1;
    assign SERIAL_DATA_IN        = s_reg.serial_data_in_pin;
    assign EXT_IRQ_0             = s_reg.ext_irq_0;
    assign EXT_IRQ_1             = s_reg.ext_irq_1;
    assign TIMER_EXT_COUNT_CLOCK = s_reg.t3i;
    assign TIMER2_CAPTURE_IN     = s_reg.timer2_capture_in;
    assign IRQ                   = s_reg.irq;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    a_sys_clock_out_pin_drive: // RULE1 RULE3
    assert property (CFG.clock_out_fuse |=> !PC_OE_N[1] && !PC_PULLUP[1]
                     && PC_OUT[1] == $past(CLK_IO_DIV))
        else $error("clock output pin not driven from the I/O clock");

    a_sys_clock_out_pin_reset: // RULE2
    assert property (disable iff (1'b0) !RST_N && CFG.clock_out_fuse |=> !PC_OE_N[1])
        else $error("clock output pin released during reset");

    a_clkin0_dir: // RULE4
    assert property (clkin0 && !CFG.clock_out_fuse |=> PC_OE_N[0]
                     && EXT_CLOCK_IN_0 == $past(PC_IN[0]))
        else $error("clock input 0 pin not forced to input");

    a_clkin0_read: // RULE5
    assert property (S_AXI_ARVALID && S_AXI_ARREADY && clkin0 &&
                     S_AXI_ARADDR == `PCDAF_OFF_PINC |=> S_AXI_RVALID && S_AXI_RDATA[0] == 1'b0)
        else $error("clock input 0 pin bit did not read zero");

    a_clkin1_dir: // RULE6
    assert property (clkin1 |=> PD_OE_N[4] && EXT_CLOCK_IN_1 == $past(PD_IN[4]))
        else $error("clock input 1 pin not forced to input");

    a_clkin1_read: // RULE7
    assert property (S_AXI_ARVALID && S_AXI_ARREADY && clkin1 &&
                     S_AXI_ARADDR == `PCDAF_OFF_DDRD |=> S_AXI_RDATA[4] == 1'b0)
        else $error("clock input 1 direction bit did not read zero");

    a_pcint_gate: // RULE8
    assert property (!s_reg.pin_change_group1_en |=> PC_PCINT == 3'h0)
        else $error("port C pin-change source passed while group disabled");

    a_spi_input: // RULE9
    assert property (spi |=> PD_OE_N[7])
        else $error("serial data pin not forced to input");

    a_spi_pullup: // RULE10
    assert property (spi && !s_reg.global_pullup_disable |=> PD_PULLUP[7] == $past(s_reg.portd[7]))
        else $error("serial data pin pull-up does not follow data bit");

    a_mod_out2: // RULE11
    assert property (T2.out_2_en && s_reg.ddrd[6] |=> !PD_OE_N[6]
                     && PD_OUT[6] == $past(T2.timer2_mod_out_2))
        else $error("modulator output 2 not on its pin");

    a_gpio_keep: // RULE13
    assert property (!T2.out_1_en |=> PD_OUT[5] == $past(s_reg.portd[5]))
        else $error("unused modulator pin not plain I/O");

    a_pud_off: // RULE18
    assert property (s_reg.global_pullup_disable |=> PD_PULLUP == 8'h00 && PC_PULLUP == 3'h0)
        else $error("pull-up active while globally disabled");

    a_irq_level:
    assert property (IRQ == |(s_reg.ists & s_reg.imask))
        else $error("interrupt level does not match unmasked status");

    c_clkin0_read: cover property (clkin0 ##1 S_AXI_RVALID);
    c_spi_mode:    cover property (spi ##2 !spi);
    c_irq_clear:   cover property (IRQ ##[1:20] !IRQ);
    c_sys_clock_out_pin_on:     cover property (CFG.clock_out_fuse ##1 !PC_OE_N[1]);

endmodule : pcdaf_top

// *** bench/pcdaf_board.sv ***
// Board model that closes the loop from the pin drivers back to the pin inputs.
`timescale 1ns/1ps
module pcdaf_board (
    input  wire logic       clock,
    input  wire logic [2:0] pc_out,
    input  wire logic [2:0] pc_oe_n,
    input  wire logic [2:0] pc_pu,
    input  wire logic [7:0] pd_out,
    input  wire logic [7:0] pd_oe_n,
    input  wire logic [7:0] pd_pu,
    input  wire logic [2:0] drv_c,
    input  wire logic [2:0] val_c,
    input  wire logic [7:0] drv_d,
    input  wire logic [7:0] val_d,
    output logic [2:0]      pc_in,
    output logic [7:0]      pd_in
);
    logic flt = 1'b0;
    // A pin nobody drives and nothing pulls up toggles every cycle, so it never reads stable.
    always @(posedge clock) begin
        flt <= ~flt;
    end
    assign pc_in = (~pc_oe_n & pc_out) | (pc_oe_n & drv_c & val_c)
                 | (pc_oe_n & ~drv_c & (pc_pu | {3{flt}}));
    assign pd_in = (~pd_oe_n & pd_out) | (pd_oe_n & drv_d & val_d)
                 | (pd_oe_n & ~drv_d & (pd_pu | {8{flt}}));
endmodule : pcdaf_board

// *** bench/port_cd_alt_function_override_tb.sv ***
// Self-checking bench for the port C and port D override block.
`timescale 1ns/1ps
`include "pcdaf_map.svh"
module port_cd_alt_function_override_tb;
    logic                     clock = 1'b0;
    logic                     rst_n = 1'b0;
    logic [7:0]               awaddr = 8'h00;
    logic [7:0]               araddr = 8'h00;
    logic [31:0]              wdata = 32'h0;
    logic                     awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic                     arvalid = 1'b0, rready = 1'b0;
    pcdaf_pkg::pcdaf_clkcfg_t cfg = '0;
    pcdaf_pkg::pcdaf_timer2_t t2 = '0;
    logic                     clk_io_div = 1'b0, div_run = 1'b0;
    logic [1:0]               irq_en = 2'h0;
    logic [2:0]               drv_c = 3'h7, val_c = 3'h0;
    logic [7:0]               drv_d = 8'hff, val_d = 8'h00;
    logic                     awready, wready, bvalid, arready, rvalid, irq;
    logic                     ext0, ext1, serial_data_in_pin, ext_irq_0, ext_irq_1, t3i, timer2_capture_in;
    logic [1:0]               bresp, rresp, rs;
    logic [31:0]              rdata, rd;
    logic [2:0]               pc_in, pc_out, pc_oe_n, pc_pu, pc_pcint;
    logic [7:0]               pd_in, pd_out, pd_oe_n, pd_pu, pd_pcint;
    int                       err_count = 0, n_compared = 0, cycles = 0;

    pcdaf_top i_dut (.CLOCK(clock), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .CFG(cfg), .T2(t2), .CLK_IO_DIV(clk_io_div),
        .EXT_IRQ_EN(irq_en), .PC_IN(pc_in), .PD_IN(pd_in), .PC_OUT(pc_out),
        .PC_OE_N(pc_oe_n), .PC_PULLUP(pc_pu), .PD_OUT(pd_out), .PD_OE_N(pd_oe_n),
        .PD_PULLUP(pd_pu), .PC_PCINT(pc_pcint), .PD_PCINT(pd_pcint),
        .EXT_CLOCK_IN_0(ext0), .EXT_CLOCK_IN_1(ext1), .SERIAL_DATA_IN(serial_data_in_pin),
        .EXT_IRQ_0(ext_irq_0), .EXT_IRQ_1(ext_irq_1), .TIMER_EXT_COUNT_CLOCK(t3i),
        .TIMER2_CAPTURE_IN(timer2_capture_in), .IRQ(irq));
    pcdaf_board i_board (.clock(clock), .pc_out(pc_out), .pc_oe_n(pc_oe_n), .pc_pu(pc_pu),
        .pd_out(pd_out), .pd_oe_n(pd_oe_n), .pd_pu(pd_pu), .drv_c(drv_c), .val_c(val_c),
        .drv_d(drv_d), .val_d(val_d), .pc_in(pc_in), .pd_in(pd_in));

    always #2 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (div_run) clk_io_div <= ~clk_io_div;
        if (cycles == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: resp %h expected %h", $time, got, exp);
        end
    endtask : chk_resp
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge clock);
        awaddr <= a;
        wdata <= 32'(d);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk_resp(bresp, er);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : axi_rd
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a);
        chk_val(rd, exp);
        chk_resp(rs, `PCDAF_RESP_OK);
    endtask : rd_chk
    // Lets a register write reach the pins and the looped-back inputs settle.
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask : settle
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        for (int a = 0; a <= 'h28; a += 4) rd_chk(8'(a), 32'h0);
        chk_val(32'(pd_oe_n), 32'hff);
        axi_rd(8'h2c);
        chk_val(rd, 32'h0);
        chk_resp(rs, `PCDAF_RESP_ERR);
        axi_wr(8'h30, 8'hff, `PCDAF_RESP_ERR);
        $display("test regs done");
    endtask : t_regs
    task automatic t_clkin();
        axi_wr(`PCDAF_OFF_PORTC, 8'h07, `PCDAF_RESP_OK);
        axi_wr(`PCDAF_OFF_DDRC, 8'h07, `PCDAF_RESP_OK);
        axi_wr(`PCDAF_OFF_PORTD, 8'hff, `PCDAF_RESP_OK);
        axi_wr(`PCDAF_OFF_DDRD, 8'hff, `PCDAF_RESP_OK);
        cfg <= {1'b0, `PCDAF_CMM_EXT, 1'b0, 1'b1};
        val_c <= 3'h1;
        val_d <= 8'h10;
        settle();
        chk_val(32'({pc_oe_n, ext0, ext1}), 32'h06);
        rd_chk(`PCDAF_OFF_PORTC, 32'h6);
        rd_chk(`PCDAF_OFF_DDRC, 32'h6);
        rd_chk(`PCDAF_OFF_PINC, 32'h6);
        cfg <= {1'b0, `PCDAF_CMM_EXT, 1'b1, 1'b1};
        settle();
        chk_val(32'({pd_oe_n, pc_oe_n[0], ext1, ext0}), 32'h082);
        rd_chk(`PCDAF_OFF_PORTD, 32'hef);
        rd_chk(`PCDAF_OFF_DDRD, 32'hef);
        rd_chk(`PCDAF_OFF_PIND, 32'hef);
        cfg <= '0;
        $display("test clock inputs done");
    endtask : t_clkin
    task automatic t_spi();
        @(posedge clock);
        t2 <= {`PCDAF_T2M_SPI, 4'h0};
        drv_d <= 8'h00;
        settle();
        chk_val(32'({pd_oe_n, serial_data_in_pin}), 32'h101);
        chk_val(32'(pd_pu), 32'h80);
        axi_wr(`PCDAF_OFF_CTRL, 8'h01, `PCDAF_RESP_OK);
        settle();
        chk_val(32'({pc_pu, pd_pu}), 32'h0);
        axi_wr(`PCDAF_OFF_CTRL, 8'h00, `PCDAF_RESP_OK);
        t2 <= '0;
        drv_d <= 8'hff;
        $display("test serial input done");
    endtask : t_spi
    task automatic t_mod();
        axi_wr(`PCDAF_OFF_PORTD, 8'h00, `PCDAF_RESP_OK);
        t2 <= {4'h0, 1'b1, 1'b1, 1'b0, 1'b1};
        settle();
        chk_val(32'({pd_oe_n, pd_out}), 32'h0040);
        @(posedge clock);
        t2 <= {4'h0, 1'b1, 1'b1, 1'b1, 1'b0};
        settle();
        chk_val(32'({pd_oe_n, pd_out}), 32'h0020);
        @(posedge clock);
        t2 <= '0;
        $display("test modulator done");
    endtask : t_mod
    task automatic t_irq();
        axi_wr(`PCDAF_OFF_DDRD, 8'h00, `PCDAF_RESP_OK);
        irq_en <= 2'h3;
        val_d <= 8'h0e;
        settle();
        chk_val(32'({ext_irq_1, ext_irq_0, t3i, timer2_capture_in}), 32'he);
        @(posedge clock);
        val_d <= 8'h01;
        settle();
        chk_val(32'({ext_irq_1, ext_irq_0, t3i, timer2_capture_in}), 32'h1);
        @(posedge clock);
        irq_en <= 2'h0;
        val_d <= 8'h0c;
        settle();
        chk_val(32'({ext_irq_1, ext_irq_0}), 32'h0);
        $display("test external inputs done");
    endtask : t_irq
    task automatic t_pcint();
        axi_wr(`PCDAF_OFF_DDRC, 8'h00, `PCDAF_RESP_OK);
        val_c <= 3'h5;
        val_d <= 8'ha5;
        axi_wr(`PCDAF_OFF_CTRL, 8'h06, `PCDAF_RESP_OK);
        axi_wr(`PCDAF_OFF_MASKC, 8'h07, `PCDAF_RESP_OK);
        axi_wr(`PCDAF_OFF_MASKD, 8'hff, `PCDAF_RESP_OK);
        settle();
        chk_val(32'({pc_pcint, pd_pcint}), 32'h5a5);
        axi_wr(`PCDAF_OFF_ISTS, 8'h03, `PCDAF_RESP_OK);
        rd_chk(`PCDAF_OFF_ISTS, 32'h0);
        val_c <= 3'h4;
        settle();
        rd_chk(`PCDAF_OFF_ISTS, 32'h1);
        chk_val(32'(irq), 32'h0);
        axi_wr(`PCDAF_OFF_IMASK, 8'h01, `PCDAF_RESP_OK);
        settle();
        chk_val(32'(irq), 32'h1);
        axi_wr(`PCDAF_OFF_ISTS, 8'h01, `PCDAF_RESP_OK);
        val_d <= 8'h25;
        settle();
        chk_val(32'(irq), 32'h0);
        rd_chk(`PCDAF_OFF_ISTS, 32'h2);
        axi_wr(`PCDAF_OFF_MASKC, 8'h00, `PCDAF_RESP_OK);
        settle();
        chk_val(32'(pc_pcint), 32'h0);
        $display("test pin change done");
    endtask : t_pcint
    task automatic fuse_chk();
        repeat (4) begin
            @(posedge clock);
            #1;
            chk_val(32'({pc_out[1], pc_oe_n[1], pc_pu[1]}), 32'({~clk_io_div, 2'b00}));
        end
    endtask : fuse_chk
    task automatic t_fuse();
        axi_wr(`PCDAF_OFF_PORTC, 8'h02, `PCDAF_RESP_OK);
        cfg <= 5'h10;
        div_run <= 1'b1;
        drv_c <= 3'h5;
        settle();
        fuse_chk();
        @(posedge clock);
        rst_n <= 1'b0;
        fuse_chk();
        @(posedge clock);
        rst_n <= 1'b1;
        $display("test clock output done");
    endtask : t_fuse
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        t_regs();
        t_clkin();
        t_spi();
        t_mod();
        t_irq();
        t_pcint();
        t_fuse();
        wrap_up();
    end
endmodule : port_cd_alt_function_override_tb
